// file: rtl/swcr_resp.sv
// Notes on behaviour
// - A zero bit pulls the line low early and releases after the internal timer.
// - A one bit never drives the line; it rises when the master lets go.
// - Identifier top byte is an 8-bit CRC over the lower 56 bits.
// - Identifier CRC goes out true, fixed at manufacture, no generator for it.
// - A 16-bit CRC generator, x^16+x^15+x^2+1, covers reads and scratchpad.
// - The 16-bit CRC always goes out inverted.
// - First checked-read page: clear, then command, both address bytes, data.
// - Later checked-read pages: clear again, then only that page's data.
// - Scratchpad write CRC: cleared, then command, address bytes, all data.
// - Scratchpad write sends CRC only when data reached end offset 1Fh.
// - Scratchpad read CRC: command, address bytes, status byte, data onward.
// - Scratchpad read sends CRC only after the final scratchpad byte.
// - Scratchpad transfers stop at offset 1Fh.
// - All-ones fill returns FFh bytes while the master reads.
// - After a good copy, AAh bytes return while the master reads.
// - During copy busy the line is not driven; all bits read one.
// - Zero fill returns 00h bytes while the master reads.
// - Zero padding sends 00h with no end until the next bus reset.
// - Plain memory read streams data up to datalog end, then fills.
// - A checked-read page block sends data to its page end, then inverted CRC.
// - Each sequence starts after bus reset and presence.
// - Reserved or out-of-range pages read as 00h, also in checked pages.
`timescale 1ns/1ps
`default_nettype none
module swcr_resp #(
  parameter logic [7:0] MEM_READ_CODE = 8'hF0,
  parameter logic [7:0] MEM_READ_CHECKED_CODE = 8'hA5,
  parameter logic [7:0] MEM_CLEAR_CODE = 8'h3C,
  parameter logic [7:0] TEMP_CONVERT_CODE = 8'h44,
  parameter logic [swcr_pkg::HOLD_W-1:0] HOLD_STD_CYC =
    swcr_pkg::HOLD_W'(swcr_pkg::RD_HOLD_STD_CYC),
  parameter logic [swcr_pkg::HOLD_W-1:0] HOLD_OD_CYC =
    swcr_pkg::HOLD_W'(swcr_pkg::RD_HOLD_OD_CYC)
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  input wire logic overdrive_in,
  input wire logic bus_reset_in,
  input wire logic frame_start_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  input wire logic [15:0] stored_ta_in,
  input wire logic [7:0] stored_es_in,
  input wire logic copy_done_in,
  input wire logic copy_ok_in,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  output logic [4:0] scratch_off_out,
  input wire logic [7:0] scratch_data_in
);
  import swcr_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    swcr_state_e st;
    logic [7:0] cmd;
    logic [1:0] cnt;
    logic [15:0] addr;
    logic [4:0] off;
    logic [15:0] crc;
    logic [7:0] fill;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_busy;
    logic [HOLD_W-1:0] hold;
    logic [2:0] sync;
    logic line_lvl;
  } swcr_regs_s;

  swcr_regs_s q;
  swcr_regs_s next_q;
  logic fall;
  logic load;
  logic [7:0] tx_byte;
  logic checked;
  logic scratch_src;
  // One byte through the generator, low bit first to match line order
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ b[i])
        r = (r >> 1) ^ CRC16_POLY_REFL;
      else
        r = r >> 1;
    end
    return r;
  endfunction
  // Pages with no storage behind them
  function automatic logic page_reserved(input logic [15:0] a);
    logic [10:0] p;
    p = a[15:PAGE_LSB];
    return ((p >= RSV1_LO) && (p <= RSV1_HI)) || ((p >= RSV2_LO) && (p <= RSV2_HI))
      || (p >= RSV3_LO);
  endfunction
  // ************************************************************
  // Line edge detection and outputs
  // ************************************************************
  // Edge is taken only once the two later stages agree, so glitches shorter than a clock are ignored
  assign fall = q.line_lvl & ~q.sync[1] & ~q.sync[2];
  assign checked = (q.cmd == MEM_READ_CHECKED_CODE);
  assign scratch_src = (q.cmd == SCRATCH_READ_CODE);
  // Open-drain: the pin only ever pulls low
  assign line_out = 1'b0;
  assign line_oe_out = (q.hold != '0);
  assign mem_addr_out = q.addr;
  assign scratch_off_out = q.off;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Slot engine, header capture and byte sequencing in one pass
  always_comb
  begin
    next_q = q;
    load = 1'b0;
    tx_byte = FILL_ZERO;
    next_q.sync = {q.sync[1:0], line_in};
    if (q.sync[1] == q.sync[2])
      next_q.line_lvl = q.sync[2];
    // Each falling edge starts a slot; a zero bit begins the pull-down at once
    if (fall && q.tx_busy)
    begin
      if (!q.tx_sh[0])
        next_q.hold = overdrive_in ? HOLD_OD_CYC : HOLD_STD_CYC;
      next_q.tx_sh = q.tx_sh >> 1;
      next_q.tx_cnt = q.tx_cnt + 4'h1;
      if (q.tx_cnt == BIT_LAST)
        next_q.tx_busy = 1'b0;
    end
    else if (q.hold != '0)
      next_q.hold = q.hold - HOLD_W'(1);
    unique case (q.st)
      SWCR_IDLE:
      begin
        if (frame_start_in)
        begin
          next_q.st = SWCR_HDR;
          next_q.cnt = HDR_CMD;
          next_q.crc = CRC16_CLEAR;
        end
      end
      SWCR_HDR:
      begin
        if (rx_valid_in)
        begin
          next_q.crc = crc16(q.crc, rx_byte_in);
          next_q.cnt = q.cnt + 2'h1;
          unique case (q.cnt)
            HDR_CMD:
            begin
              next_q.cmd = rx_byte_in;
              if (rx_byte_in == SCRATCH_READ_CODE)
              begin
                next_q.st = SWCR_TX_HDR;
                next_q.cnt = HDR_CMD;
                next_q.off = stored_ta_in[4:0];
              end
              else if ((rx_byte_in == MEM_CLEAR_CODE) || (rx_byte_in == TEMP_CONVERT_CODE))
              begin
                next_q.st = SWCR_FILL;
                next_q.fill = FILL_ONES;
              end
              else if ((rx_byte_in != SCRATCH_WRITE_CODE) && (rx_byte_in != SCRATCH_COPY_CODE)
                && (rx_byte_in != MEM_READ_CODE) && (rx_byte_in != MEM_READ_CHECKED_CODE))
                next_q.st = SWCR_IDLE;
            end
            HDR_TA_LOW:
              next_q.addr[7:0] = rx_byte_in;
            HDR_TA_HIGH:
            begin
              next_q.addr[15:8] = rx_byte_in;
              next_q.off = q.addr[4:0];
              if (q.cmd == SCRATCH_WRITE_CODE)
                next_q.st = SWCR_SW_DATA;
              else if ((q.cmd == MEM_READ_CODE) && ({rx_byte_in, q.addr[7:0]} > MEM_END))
              begin
                next_q.st = SWCR_FILL;
                next_q.fill = FILL_ZERO;
              end
              else if (q.cmd != SCRATCH_COPY_CODE)
                next_q.st = SWCR_TX_DATA;
            end
            HDR_ES:
              next_q.st = SWCR_BUSY;
          endcase
        end
      end
      SWCR_SW_DATA:
      begin
        // Write may start anywhere; CRC follows only if offset 1Fh was written
        if (rx_valid_in)
        begin
          next_q.crc = crc16(q.crc, rx_byte_in);
          if (q.off == SCR_LAST)
            next_q.st = SWCR_CRC_LO;
          else
            next_q.off = q.off + 5'h1;
        end
      end
      SWCR_BUSY:
      begin
        // Nothing loaded, so every slot reads as one until the copy finishes
        if (copy_done_in)
        begin
          next_q.st = SWCR_FILL;
          next_q.fill = copy_ok_in ? FILL_COPY_OK : FILL_ONES;
        end
      end
      SWCR_TX_HDR, SWCR_TX_DATA, SWCR_CRC_LO, SWCR_CRC_HI, SWCR_FILL:
      begin
        load = ~q.tx_busy;
        if (load)
        begin
          unique case (q.st)
            SWCR_TX_HDR:
            begin
              tx_byte = (q.cnt == HDR_CMD) ? stored_ta_in[7:0]
                : (q.cnt == HDR_TA_LOW) ? stored_ta_in[15:8] : stored_es_in;
              next_q.crc = crc16(q.crc, tx_byte);
              next_q.cnt = q.cnt + 2'h1;
              if (q.cnt == HDR_TA_HIGH)
                next_q.st = SWCR_TX_DATA;
            end
            SWCR_TX_DATA:
            begin
              if (scratch_src)
              begin
                tx_byte = scratch_data_in;
                next_q.crc = crc16(q.crc, tx_byte);
                if (q.off == SCR_LAST)
                  next_q.st = SWCR_CRC_LO;
                else
                  next_q.off = q.off + 5'h1;
              end
              else
              begin
                tx_byte = page_reserved(q.addr) ? FILL_ZERO : mem_data_in;
                next_q.crc = crc16(q.crc, tx_byte);
                next_q.addr = q.addr + 16'h0001;
                if (checked)
                begin
                  if (q.addr[4:0] == PAGE_LAST)
                    next_q.st = SWCR_CRC_LO;
                end
                else if (q.addr == MEM_END)
                begin
                  next_q.st = SWCR_FILL;
                  next_q.fill = FILL_ZERO;
                end
              end
            end
            SWCR_CRC_LO:
            begin
              tx_byte = ~q.crc[7:0];
              next_q.st = SWCR_CRC_HI;
            end
            SWCR_CRC_HI:
            begin
              tx_byte = ~q.crc[15:8];
              if (checked)
              begin
                // Next page starts from a cleared generator with data only
                next_q.st = SWCR_TX_DATA;
                next_q.crc = CRC16_CLEAR;
              end
              else
              begin
                next_q.st = SWCR_FILL;
                next_q.fill = FILL_ONES;
              end
            end
            default:
              tx_byte = q.fill;
          endcase
        end
      end
      default:
        next_q.st = SWCR_IDLE;
    endcase
    if (load)
    begin
      next_q.tx_sh = tx_byte;
      next_q.tx_busy = 1'b1;
      next_q.tx_cnt = '0;
    end
    // The identifier check byte is a fixed stored value sent true; no generator here
    // A bus reset ends any sequence; the next one waits for a fresh start
    if (bus_reset_in)
    begin
      next_q.st = SWCR_IDLE;
      next_q.tx_busy = 1'b0;
      next_q.hold = '0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Idle line level after reset is high so no false edge is seen at release
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q <= '0;
      q.st <= SWCR_IDLE;
      q.sync <= 3'b111;
      q.line_lvl <= 1'b1;
      q.fill <= FILL_ONES;
    end
    else
      q <= next_q;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  zero_pull_a:
  assert property (fall && q.tx_busy && !q.tx_sh[0] && !bus_reset_in |=> line_oe_out [*8])
    else $error("zero bit did not hold the line low");
  one_float_a:
  assert property (fall && q.tx_busy && q.tx_sh[0] && (q.hold == '0) |=> !line_oe_out)
    else $error("one bit drove the line");
  crc_low_inv_a:
  assert property (load && (q.st == SWCR_CRC_LO) |=> (q.tx_sh == ~$past(q.crc[7:0])))
    else $error("low CRC byte not inverted");
  busy_quiet_a:
  assert property ((q.st == SWCR_BUSY) && (q.hold == '0) |=> !line_oe_out)
    else $error("line driven during copy busy");
  bus_reset_idle_a:
  assert property (bus_reset_in |=> (q.st == SWCR_IDLE) && !line_oe_out)
    else $error("bus reset did not end the sequence");
  mem_end_fill_a:
  assert property (load && (q.st == SWCR_TX_DATA) && !checked && !scratch_src
    && (q.addr == MEM_END) && !bus_reset_in |=> (q.st == SWCR_FILL) && (q.fill == FILL_ZERO))
    else $error("memory end did not start zero fill");
  scratch_end_crc_a:
  assert property (load && (q.st == SWCR_TX_DATA) && scratch_src && (q.off == SCR_LAST)
    && !bus_reset_in |=> (q.st == SWCR_CRC_LO))
    else $error("scratchpad end did not lead to CRC");
  reserved_zero_a:
  assert property (load && (q.st == SWCR_TX_DATA) && !scratch_src && page_reserved(q.addr)
    |=> (q.tx_sh == FILL_ZERO))
    else $error("reserved page returned nonzero data");
  page_crc_a:
  assert property (load && (q.st == SWCR_TX_DATA) && checked && (q.addr[4:0] == PAGE_LAST)
    && !bus_reset_in |=> (q.st == SWCR_CRC_LO))
    else $error("page end did not lead to CRC");
  page_clear_a:
  assert property (load && (q.st == SWCR_CRC_HI) && checked && !bus_reset_in
    |=> (q.crc == CRC16_CLEAR) && (q.st == SWCR_TX_DATA))
    else $error("generator not cleared for next page");
  write_end_crc_a:
  assert property ((q.st == SWCR_SW_DATA) && rx_valid_in && (q.off != SCR_LAST) && !bus_reset_in
    |=> (q.st == SWCR_SW_DATA))
    else $error("CRC sent before scratchpad end");

endmodule // swcr_resp
`default_nettype wire

// file: rtl/swcr_pkg.sv
`default_nettype none
// ************************************************************
// Shared constants for the single-wire response logic
// ************************************************************
package swcr_pkg;

  // Clock and read-slot release timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RD_HOLD_STD_NS = 30000;
  localparam int RD_HOLD_OD_NS = 3000;
  localparam int RD_HOLD_STD_CYC = (RD_HOLD_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HOLD_OD_CYC = (RD_HOLD_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 10;

  // Command codes carried in the byte stream
  localparam logic [7:0] SCRATCH_WRITE_CODE = 8'h0F;
  localparam logic [7:0] SCRATCH_READ_CODE = 8'hAA;
  localparam logic [7:0] SCRATCH_COPY_CODE = 8'h55;

  // Fill bytes
  localparam logic [7:0] FILL_ONES = 8'hFF;
  localparam logic [7:0] FILL_COPY_OK = 8'hAA;
  localparam logic [7:0] FILL_ZERO = 8'h00;

  // Memory geometry
  localparam logic [15:0] MEM_END = 16'h17FF;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [4:0] SCR_LAST = 5'h1F;
  localparam int PAGE_LSB = 5;
  localparam logic [10:0] RSV1_LO = 11'h014;
  localparam logic [10:0] RSV1_HI = 11'h03F;
  localparam logic [10:0] RSV2_LO = 11'h044;
  localparam logic [10:0] RSV2_HI = 11'h07F;
  localparam logic [10:0] RSV3_LO = 11'h0C0;

  // CRC16 generator, reflected form of x^16+x^15+x^2+1
  localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC16_CLEAR = 16'h0000;

  // Byte engine
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] HDR_CMD = 2'h0;
  localparam logic [1:0] HDR_TA_LOW = 2'h1;
  localparam logic [1:0] HDR_TA_HIGH = 2'h2;
  localparam logic [1:0] HDR_ES = 2'h3;

  typedef enum logic [3:0] {
    SWCR_IDLE, SWCR_HDR, SWCR_SW_DATA, SWCR_TX_HDR, SWCR_TX_DATA,
    SWCR_CRC_LO, SWCR_CRC_HI, SWCR_BUSY, SWCR_FILL
  } swcr_state_e;

endpackage
`default_nettype wire

// file: bench/swcr_master.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bus master model: read slots on the open-drain line
// ************************************************************
module swcr_master #(
  parameter int HOLD_STD = 16,
  parameter int HOLD_OD = 10
) (
  input wire logic sys_clk_in,
  input wire logic line_in,
  input wire logic overdrive_in,
  output logic line_low_out
);
  initial line_low_out = 1'b0;

  // One slot per bit, least significant bit first
  // Sampling soon after release keeps us well inside the device hold window
  task automatic read_byte(output logic [7:0] value);
    int hold;
    hold = overdrive_in ? HOLD_OD : HOLD_STD;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge sys_clk_in);
      line_low_out = 1'b1;
      repeat (6) @(negedge sys_clk_in);
      line_low_out = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      value[i] = line_in;
      // Wait out the rest of the slot so the device recovers
      repeat (hold + 4) @(negedge sys_clk_in);
    end
  endtask
endmodule // swcr_master
`default_nettype wire

// file: bench/swcr_resp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swcr_resp_tb;
  import swcr_pkg::*;
  localparam int HOLD_S = 16;
  localparam int HOLD_O = 10;
  localparam int LIMIT = 60000;
  logic sys_clk, rstn, line_out, line_oe, overdrive, bus_reset, frame_start;
  logic rx_valid, copy_done, copy_ok, master_low, bus_line;
  logic [7:0] rx_byte, stored_es, mem_data, scr_data;
  logic [15:0] stored_ta, mem_addr, crc, oe_run;
  logic [4:0] scr_off;
  int miscompares, tests_run, cycles;

  // ************************************************************
  // Device, master and memory models
  // ************************************************************
  // Wired-AND of both open-drain parties over the pull-up
  assign bus_line = (line_oe ? line_out : 1'b1) & ~master_low;
  // Simple address-derived contents, easy to predict
  assign mem_data = mem_addr[7:0] ^ 8'h5a;
  assign scr_data = {3'b101, scr_off};

  swcr_resp #(
    .HOLD_STD_CYC(HOLD_W'(HOLD_S)),
    .HOLD_OD_CYC(HOLD_W'(HOLD_O))
  ) i_dut (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .line_in(bus_line), .line_out(line_out),
    .line_oe_out(line_oe), .overdrive_in(overdrive), .bus_reset_in(bus_reset),
    .frame_start_in(frame_start), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
    .stored_ta_in(stored_ta), .stored_es_in(stored_es), .copy_done_in(copy_done),
    .copy_ok_in(copy_ok), .mem_addr_out(mem_addr), .mem_data_in(mem_data),
    .scratch_off_out(scr_off), .scratch_data_in(scr_data)
  );

  swcr_master #(.HOLD_STD(HOLD_S), .HOLD_OD(HOLD_O)) i_master (
    .sys_clk_in(sys_clk), .line_in(bus_line), .overdrive_in(overdrive),
    .line_low_out(master_low)
  );

  always #20 sys_clk = ~sys_clk;

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Reflected generator, bits enter least significant first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC16_POLY_REFL) : (c >> 1);
    return c;
  endfunction

  // Every zero bit must hold the line for exactly the hold count
  always @(negedge sys_clk)
  begin
    if (line_oe === 1'b1)
      oe_run = oe_run + 16'h0001;
    else if (oe_run != 16'h0000)
    begin
      check(oe_run, overdrive ? 16'(HOLD_O) : 16'(HOLD_S));
      oe_run = 16'h0000;
    end
  end

  // Hang guard; the run needs far fewer cycles than this
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ************************************************************
  // Stimulus tasks
  // ************************************************************
  task automatic send_byte(input logic [7:0] b);
    @(negedge sys_clk);
    rx_byte = b;
    rx_valid = 1'b1;
    @(negedge sys_clk);
    rx_valid = 1'b0;
  endtask

  // Bus reset, presence phase done, then command and optional address
  task automatic start_cmd(input logic [7:0] cmd, input logic [15:0] ta, input int n,
                           input logic od);
    @(negedge sys_clk);
    overdrive = od;
    bus_reset = 1'b1;
    @(negedge sys_clk);
    bus_reset = 1'b0;
    @(negedge sys_clk);
    frame_start = 1'b1;
    @(negedge sys_clk);
    frame_start = 1'b0;
    send_byte(cmd);
    crc = crc_upd(CRC16_CLEAR, cmd);
    if (n > 1)
    begin
      send_byte(ta[7:0]);
      send_byte(ta[15:8]);
      crc = crc_upd(crc_upd(crc, ta[7:0]), ta[15:8]);
    end
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic read_exp(input logic [7:0] e);
    logic [7:0] b;
    i_master.read_byte(b);
    check({8'h00, b}, {8'h00, e});
    crc = crc_upd(crc, e);
  endtask

  // Inverted generator, low byte first, then a fresh generator
  task automatic read_crc();
    logic [15:0] e;
    logic [7:0] lo, hi;
    e = ~crc;
    i_master.read_byte(lo);
    i_master.read_byte(hi);
    check({hi, lo}, e);
    crc = CRC16_CLEAR;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_read_plain();
    start_cmd(8'hf0, 16'h17fe, 3, 1'b0);
    read_exp(8'hfe ^ 8'h5a);
    read_exp(8'hff ^ 8'h5a);
    read_exp(FILL_ZERO);
    read_exp(FILL_ZERO);
  endtask

  // Last two bytes of a real page, then a reserved page of zeros
  task automatic test_read_checked();
    start_cmd(8'ha5, 16'h027e, 3, 1'b0);
    read_exp(8'h7e ^ 8'h5a);
    read_exp(8'h7f ^ 8'h5a);
    read_crc();
    for (int i = 0; i < 32; i++)
      read_exp(FILL_ZERO);
    read_crc();
  endtask

  task automatic test_scratch_read();
    stored_ta = 16'h021c;
    stored_es = 8'h1f;
    start_cmd(SCRATCH_READ_CODE, 16'h0000, 1, 1'b1);
    read_exp(8'h1c);
    read_exp(8'h02);
    read_exp(8'h1f);
    for (int i = 28; i < 32; i++)
      read_exp({3'b101, 5'(i)});
    read_crc();
    read_exp(FILL_ONES);
  endtask

  task automatic test_scratch_write();
    start_cmd(SCRATCH_WRITE_CODE, 16'h021e, 3, 1'b0);
    send_byte(8'h11);
    send_byte(8'h22);
    crc = crc_upd(crc_upd(crc, 8'h11), 8'h22);
    repeat (4) @(negedge sys_clk);
    read_crc();
    read_exp(FILL_ONES);
    // Stopping short of the last offset leaves the line undriven
    start_cmd(SCRATCH_WRITE_CODE, 16'h0200, 3, 1'b0);
    send_byte(8'h33);
    repeat (4) @(negedge sys_clk);
    read_exp(FILL_ONES);
  endtask

  task automatic test_copy_and_fill();
    start_cmd(SCRATCH_COPY_CODE, 16'h0200, 3, 1'b1);
    send_byte(8'h1f);
    repeat (4) @(negedge sys_clk);
    read_exp(FILL_ONES);
    @(negedge sys_clk);
    copy_ok = 1'b1;
    copy_done = 1'b1;
    @(negedge sys_clk);
    copy_done = 1'b0;
    repeat (4) @(negedge sys_clk);
    read_exp(FILL_COPY_OK);
    read_exp(FILL_COPY_OK);
    start_cmd(8'h3c, 16'h0000, 1, 1'b0);
    read_exp(FILL_ONES);
    start_cmd(8'h44, 16'h0000, 1, 1'b0);
    read_exp(FILL_ONES);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    overdrive = 1'b0;
    bus_reset = 1'b0;
    frame_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    copy_done = 1'b0;
    copy_ok = 1'b0;
    stored_ta = 16'h0000;
    stored_es = 8'h00;
    oe_run = 16'h0000;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    test_read_plain();
    test_read_checked();
    test_scratch_read();
    test_scratch_write();
    test_copy_and_fill();
    repeat (40) @(negedge sys_clk);
    end_sim();
  end
endmodule // swcr_resp_tb
`default_nettype wire
